// ==== hdl/tpd_pkg.sv ====
// package: register map, field layout and constants of the tap/pulse decoder
// assumes a 32-bit axi4-lite register bus and a 50 MHz clock
package tpd_pkg;
  localparam int          BIN_W        = 16;
  localparam int          POS_W        = 6;
  localparam logic [5:0]  POS_MAX      = 6'h3e;
  localparam logic [5:0]  POS_INVALID  = 6'h3f;
  localparam int          TBL_DEPTH    = 64;
  localparam int          MV_SHIFT     = 15;
  // byte addresses
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_TAP_CFG = 8'h04;
  localparam logic [7:0]  ADDR_TAP_ST  = 8'h08;
  localparam logic [7:0]  ADDR_TBL_IDX = 8'h0c;
  localparam logic [7:0]  ADDR_TBL_DAT = 8'h10;
  localparam logic [7:0]  ADDR_COUNT   = 8'h14;
  localparam logic [7:0]  ADDR_MFACT   = 8'h18;
  localparam logic [7:0]  ADDR_READING = 8'h1c;
  localparam logic [7:0]  ADDR_MV_CFG  = 8'h20;
  localparam logic [7:0]  ADDR_MV_VAL  = 8'h24;
  localparam logic [7:0]  ADDR_LIMIT   = 8'h28;
  // field positions
  localparam int CTRL_MODE_LSB  = 2;
  localparam int CTRL_CLR_BIT   = 3;
  localparam int CFG_BITS_LSB   = 8;
  localparam int CFG_OFS_LSB    = 16;
  localparam int CFG_STEP_LSB   = 24;
  localparam int ST_VALID_BIT   = 8;
  localparam int ST_WORD_LSB    = 16;
  localparam int MV_UNIT_LSB    = 16;
  localparam int MV_DIG_LSB     = 24;
  // reset values
  localparam logic [31:0] TAP_CFG_RST  = 32'h01000110;
  localparam logic [31:0] MFACT_RST    = 32'h000003e8;
  localparam logic [31:0] MV_CFG_RST   = 32'h00000064;
  localparam logic [31:0] LIMIT_RST    = 32'h00000000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {
    CODE_BINARY, CODE_BCD, CODE_ONEHOT, CODE_TABLE
  } tpd_code_type;
  typedef enum logic {PULSE_SINGLE, PULSE_DOUBLE} tpd_pulse_type;
endpackage : tpd_pkg

// ==== hdl/tpd_div_if.sv ====
// interface: request and answer between the top and the divider
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface tpd_div_if;
  logic        start;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic        busy;
  logic        done;
  logic [31:0] quotient;
  modport master (output start, dividend, divisor,
                  input busy, done, quotient);
  modport slave  (input start, dividend, divisor,
                  output busy, done, quotient);
endinterface : tpd_div_if

// ==== hdl/tpd_divider.sv ====
// restoring divider, one quotient bit per clock
// assumes divisor is nonzero; start is taken only while idle
`timescale 1ns/100ps
module tpd_divider
  import tpd_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  rstn_in,
  tpd_div_if.slave   div
);
  logic [31:0] rem_reg;
  logic [31:0] quo_reg;
  logic [31:0] dsr_reg;
  logic [5:0]  cnt_reg;
  logic [32:0] trial;

  assign trial = {rem_reg, quo_reg[31]} - {1'b0, dsr_reg};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rem_reg  <= 32'h0;
      quo_reg  <= 32'h0;
      dsr_reg  <= 32'h0;
      cnt_reg  <= 6'h0;
      div.busy <= 1'b0;
      div.done <= 1'b0;
      div.quotient <= 32'h0;
    end else begin
      div.done <= 1'b0;
      if (!div.busy && div.start) begin
        rem_reg  <= 32'h0;
        quo_reg  <= div.dividend;
        dsr_reg  <= div.divisor;
        cnt_reg  <= 6'h20;
        div.busy <= 1'b1;
      end else if (div.busy) begin
        if (!trial[32]) begin
          rem_reg <= trial[31:0];
          quo_reg <= {quo_reg[30:0], 1'b1};
        end else begin
          rem_reg <= {rem_reg[30:0], quo_reg[31]};
          quo_reg <= {quo_reg[30:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 6'h1;
        if (cnt_reg == 6'h1) begin
          div.busy <= 1'b0;
          div.done <= 1'b1;
          div.quotient <= trial[32] ? {quo_reg[30:0], 1'b0}
                                    : {quo_reg[30:0], 1'b1};
        end
      end
    end
  end
endmodule : tpd_divider

// ==== hdl/tpd_top.sv ====
// tap position decoder, pulse meter and user value scaling, axi4-lite regs
// assumes pins are asynchronous; mv_in comes from logic on clk_in
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
// How it works
// - tap position comes from binary inputs as a word, 62 positions max
// - code is binary, bcd or one-hot; positions, bits, offset, step set
// - with no standard code a lookup table maps each pattern of the low 6 bits
// - a recognised pattern gives a position from 1 to 62
// - an unrecognised pattern reports position 63
// - bit count sets how many inputs form the word
// - a display offset is added to the decoded value outside table mode
// - a step setting scales spacing between reported positions outside table mode
// - metered reading sign follows power flow direction
// - single mode counts one per complete input pulse
// - double mode counts every rising and every falling edge
// - metered reading is pulse count divided by conversion factor
// - measured value has unit, factor and fractional digit count
// - limit value threshold is loaded as initial value at startup
// - scaled measured value is factor times input fraction times ten to the digit count
module tpd_top
  import tpd_pkg::*;
#(
  parameter logic [31:0] LIMIT_INIT = LIMIT_RST
) (
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire logic [BIN_W-1:0]  binary_input_in,
  input  wire logic              pulse_in,
  input  wire logic              reverse_flow_in,
  input  wire logic [15:0]       mv_in,
  input  wire logic [7:0]        s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [7:0]        s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  output logic [POS_W-1:0]       tap_position_indication_out,
  output logic                   tap_valid_out,
  output logic [31:0]            pulse_metered_value_out,
  output logic [31:0]            user_measured_value_out,
  output logic [31:0]            user_limit_value_out,
  output logic                   below_limit_out
);
  logic [BIN_W-1:0] bin_s1_reg;
  logic [BIN_W-1:0] bin_s2_reg;
  logic [1:0]       pulse_sy_reg;
  logic [1:0]       dir_sy_reg;
  logic             pulse_prev_reg;
  logic [31:0]      ctrl_reg;
  logic [31:0]      cfg_reg;
  logic [5:0]       tbl_idx_reg;
  logic [5:0]       tbl_mem [TBL_DEPTH];
  logic [31:0]      count_reg;
  logic [31:0]      mfact_reg;
  logic [31:0]      mv_cfg_reg;
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             aw_full_reg;
  logic             w_full_reg;
  logic             div_start_reg;
  logic [31:0]      div_dividend_reg;
  logic [31:0]      div_divisor_reg;
  tpd_div_if        div_bus ();

  tpd_code_type     code;
  tpd_pulse_type    pmode;
  logic [5:0]       npos, ofs, step;
  logic [4:0]       nbits;
  logic [BIN_W-1:0] mask, word;
  logic [7:0]       dec_val;
  logic             dec_ok;
  logic [15:0]      pos_calc;
  logic [5:0]       pos_next;
  logic             do_write, clr_write;
  logic [31:0]      wr_mask, rd_next;
  logic [31:0]      count_base;
  logic             rd_hit;
  logic [9:0]       pow10;
  logic [47:0]      mv_prod;

  assign code  = tpd_code_type'(ctrl_reg[1:0]);
  assign pmode = tpd_pulse_type'(ctrl_reg[CTRL_MODE_LSB]);
  assign npos  = cfg_reg[5:0];
  assign nbits = cfg_reg[CFG_BITS_LSB +: 5];
  assign ofs   = cfg_reg[CFG_OFS_LSB +: 6];
  assign step  = cfg_reg[CFG_STEP_LSB +: 6];

  // pins cross into clk_in through two flops before use
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bin_s1_reg   <= '0;
      bin_s2_reg   <= '0;
      pulse_sy_reg <= 2'h0;
      dir_sy_reg   <= 2'h0;
    end else begin
      bin_s1_reg   <= binary_input_in;
      bin_s2_reg   <= bin_s1_reg;
      pulse_sy_reg <= {pulse_sy_reg[0], pulse_in};
      dir_sy_reg   <= {dir_sy_reg[0], reverse_flow_in};
    end
  end

  always_comb begin
    mask = '0;
    for (int i = 0; i < BIN_W; i++) begin
      mask[i] = (5'(i) < nbits);
    end
    if (nbits >= 5'(BIN_W)) begin
      mask = '1;
    end
  end
  assign word = bin_s2_reg & mask;

  always_comb begin
    dec_val = 8'h0;
    dec_ok  = 1'b0;
    unique case (code)
      CODE_BINARY: begin
        dec_val = word[7:0];
        dec_ok  = (word != '0) && (word <= {10'h0, npos});
      end
      CODE_BCD: begin
        dec_val = 8'(word[7:4] * 4'ha) + {4'h0, word[3:0]};
        dec_ok  = (word[3:0] <= 4'h9) && (word[7:4] <= 4'h9)
                  && (word[15:8] == 8'h0) && (dec_val != 8'h0)
                  && (dec_val <= {2'h0, npos});
      end
      CODE_ONEHOT: begin
        for (int i = 0; i < BIN_W; i++) begin
          if (word[i]) begin
            dec_val = 8'(i + 1);
          end
        end
        dec_ok = (word != '0) && ((word & (word - 16'h1)) == '0)
                 && (dec_val <= {2'h0, npos});
      end
      CODE_TABLE: begin
        // table entry; zero entry marks no position
        dec_val = {2'h0, tbl_mem[word[5:0]]};
        dec_ok  = (word[15:6] == '0) && (dec_val != 8'h0);
      end
    endcase
  end

  // position is value times step plus offset, or the table entry itself in table mode
  assign pos_calc = (code == CODE_TABLE) ? {8'h0, dec_val}
                  : 16'(dec_val * step) + {10'h0, ofs};
  assign pos_next = (dec_ok && pos_calc != 16'h0
                     && pos_calc <= {10'h0, POS_MAX})
                  ? pos_calc[5:0] : POS_INVALID;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tap_position_indication_out <= POS_INVALID;
      tap_valid_out               <= 1'b0;
    end else begin
      tap_position_indication_out <= pos_next;
      tap_valid_out               <= (pos_next != POS_INVALID);
    end
  end

  // pulse counter; an edge in the clearing cycle still counts
  assign count_base = clr_write ? 32'h0 : count_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pulse_prev_reg <= 1'b0;
      count_reg      <= 32'h0;
    end else begin
      pulse_prev_reg <= pulse_sy_reg[1];
      count_reg      <= count_base;
      if (pmode == PULSE_DOUBLE) begin
        if (pulse_sy_reg[1] != pulse_prev_reg) begin
          count_reg <= count_base + 32'h1;
        end
      end else begin
        // count at falling edge, pulse complete
        if (!pulse_sy_reg[1] && pulse_prev_reg) begin
          count_reg <= count_base + 32'h1;
        end
      end
    end
  end

  // reading refreshed by a free-running divide
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_start_reg    <= 1'b0;
      div_dividend_reg <= 32'h0;
      div_divisor_reg  <= 32'h1;
      pulse_metered_value_out <= 32'h0;
    end else begin
      div_start_reg <= !div_bus.busy && !div_start_reg;
      if (!div_bus.busy && !div_start_reg) begin
        div_dividend_reg <= count_reg;
        // zero factor would hang the quotient at all ones
        div_divisor_reg  <= (mfact_reg == 32'h0) ? 32'h1 : mfact_reg;
      end
      if (div_bus.done) begin
        pulse_metered_value_out <= dir_sy_reg[1] ? -div_bus.quotient
                                                 : div_bus.quotient;
      end
    end
  end
  assign div_bus.start    = div_start_reg;
  assign div_bus.dividend = div_dividend_reg;
  assign div_bus.divisor  = div_divisor_reg;

  tpd_divider u_div (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .div     (div_bus.slave)
  );

  // fractional digits scale by a power of ten
  always_comb begin
    unique case (mv_cfg_reg[MV_DIG_LSB +: 2])
      2'h0: pow10 = 10'h001;
      2'h1: pow10 = 10'h00a;
      2'h2: pow10 = 10'h064;
      2'h3: pow10 = 10'h3e8;
    endcase
  end
  // full-scale input is 2^15, output is factor times fraction times the power of ten
  assign mv_prod = 48'(mv_cfg_reg[15:0]) * 48'(mv_in) * 48'(pow10);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      user_measured_value_out <= 32'h0;
      below_limit_out         <= 1'b0;
    end else begin
      user_measured_value_out <= mv_prod[MV_SHIFT +: 32];
      below_limit_out <= mv_prod[MV_SHIFT +: 32] < user_limit_value_out;
    end
  end

  // axi write: address and data captured in either order
  assign do_write  = aw_full_reg && w_full_reg && !s_axi_bvalid_out;
  assign clr_write = do_write && (aw_addr_reg == ADDR_CTRL)
                     && w_strb_reg[0] && w_data_reg[CTRL_CLR_BIT];
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_mask[8*b +: 8] = {8{w_strb_reg[b]}};
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_full_reg       <= 1'b0;
      w_full_reg        <= 1'b0;
      aw_addr_reg       <= 8'h0;
      w_data_reg        <= 32'h0;
      w_strb_reg        <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_reg       <= 1'b1;
        aw_addr_reg       <= {s_axi_awaddr_in[7:2], 2'h0};
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_reg       <= 1'b1;
        w_data_reg       <= s_axi_wdata_in;
        w_strb_reg       <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        unique case (aw_addr_reg)
          ADDR_CTRL, ADDR_TAP_CFG, ADDR_TBL_IDX, ADDR_TBL_DAT,
          ADDR_MFACT, ADDR_MV_CFG, ADDR_LIMIT,
          ADDR_TAP_ST, ADDR_COUNT, ADDR_READING, ADDR_MV_VAL:
            s_axi_bresp_out <= RESP_OKAY;
          default: s_axi_bresp_out <= RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        aw_full_reg       <= 1'b0;
        w_full_reg        <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // writable registers; clear bit self-clears
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_reg    <= 32'h0;
      cfg_reg     <= TAP_CFG_RST;
      tbl_idx_reg <= 6'h0;
      mfact_reg   <= MFACT_RST;
      mv_cfg_reg  <= MV_CFG_RST;
      user_limit_value_out <= LIMIT_INIT;
    end else if (do_write) begin
      unique case (aw_addr_reg)
        ADDR_CTRL: ctrl_reg <= ((w_data_reg & wr_mask)
                               | (ctrl_reg & ~wr_mask)) & 32'h7;
        ADDR_TAP_CFG: cfg_reg <= (w_data_reg & wr_mask)
                                 | (cfg_reg & ~wr_mask);
        ADDR_TBL_IDX: if (w_strb_reg[0]) tbl_idx_reg <= w_data_reg[5:0];
        ADDR_MFACT: mfact_reg <= (w_data_reg & wr_mask)
                                 | (mfact_reg & ~wr_mask);
        ADDR_MV_CFG: mv_cfg_reg <= (w_data_reg & wr_mask)
                                   | (mv_cfg_reg & ~wr_mask);
        ADDR_LIMIT: user_limit_value_out <= (w_data_reg & wr_mask)
                                 | (user_limit_value_out & ~wr_mask);
        default: ;
      endcase
    end
  end

  // table is written one entry per access, no reset needed
  always_ff @(posedge clk_in) begin
    if (do_write && aw_addr_reg == ADDR_TBL_DAT && w_strb_reg[0]) begin
      tbl_mem[tbl_idx_reg] <= w_data_reg[5:0];
    end
  end

  // axi read: one cycle from address to data
  always_comb begin
    rd_hit  = 1'b1;
    rd_next = 32'h0;
    unique case ({s_axi_araddr_in[7:2], 2'h0})
      ADDR_CTRL:    rd_next = ctrl_reg;
      ADDR_TAP_CFG: rd_next = cfg_reg;
      ADDR_TAP_ST:  begin
        rd_next[5:0]              = tap_position_indication_out;
        rd_next[ST_VALID_BIT]     = tap_valid_out;
        rd_next[ST_WORD_LSB +: 16] = word;
      end
      ADDR_TBL_IDX: rd_next = {26'h0, tbl_idx_reg};
      ADDR_TBL_DAT: rd_next = {26'h0, tbl_mem[tbl_idx_reg]};
      ADDR_COUNT:   rd_next = count_reg;
      ADDR_MFACT:   rd_next = mfact_reg;
      ADDR_READING: rd_next = pulse_metered_value_out;
      ADDR_MV_CFG:  rd_next = mv_cfg_reg;
      ADDR_MV_VAL:  rd_next = user_measured_value_out;
      ADDR_LIMIT:   rd_next = user_limit_value_out;
      default:      rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0;
      s_axi_rresp_out   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= rd_next;
        s_axi_rresp_out   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end
endmodule : tpd_top

// ==== tb/tpd_field_model.sv ====
// field model: tap contacts, pulse meter and power flow direction pins
// assumes the bench calls its tasks from one process, on clk_in edges
`timescale 1ns/100ps
module tpd_field_model
  import tpd_pkg::*;
(
  input  wire logic        clk_in,
  output logic [BIN_W-1:0] word_out,
  output logic             pulse_out,
  output logic             reverse_out
);
  initial begin
    word_out    = '0;
    pulse_out   = 1'b0;
    reverse_out = 1'b0;
  end
  task set_word(input logic [BIN_W-1:0] w);
    @(posedge clk_in);
    word_out <= w;
  endtask : set_word
  // whole pulses only
  // wide phases so the two-flop sync never loses one
  task pulses(input int n);
    repeat (n) begin
      @(posedge clk_in);
      pulse_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      pulse_out <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask : pulses
  task set_flow(input logic r);
    @(posedge clk_in);
    reverse_out <= r;
  endtask : set_flow
endmodule : tpd_field_model

// ==== tb/tpd_top_asserts.sv ====
// checker: handshake and tap output relations at the top's ports
// assumes it is bound to tpd_top and sees only its ports
`timescale 1ns/100ps
module tpd_top_asserts
  import tpd_pkg::*;
#(
  parameter logic [31:0] LIMIT_INIT = LIMIT_RST
) (
  input wire logic             clk_in,
  input wire logic             rstn_in,
  input wire logic             s_axi_awvalid_in,
  input wire logic             s_axi_awready_out,
  input wire logic             s_axi_wvalid_in,
  input wire logic             s_axi_wready_out,
  input wire logic             s_axi_bvalid_out,
  input wire logic             s_axi_bready_in,
  input wire logic             s_axi_arvalid_in,
  input wire logic             s_axi_arready_out,
  input wire logic             s_axi_rvalid_out,
  input wire logic             s_axi_rready_in,
  input wire logic [POS_W-1:0] tap_position_indication_out,
  input wire logic             tap_valid_out,
  input wire logic [31:0]      user_limit_value_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_VALID_MATCH: assert property (
    tap_valid_out == (tap_position_indication_out != POS_INVALID))
    else $error("valid flag disagrees with position");
  AST_POS_RANGE: assert property (
    tap_valid_out |-> tap_position_indication_out >= 6'h01
      && tap_position_indication_out <= POS_MAX)
    else $error("valid position out of range");
  AST_RESET_POS: assert property (
    $rose(rstn_in) |-> !tap_valid_out
      && tap_position_indication_out == POS_INVALID)
    else $error("position not invalid after reset");
  AST_LIMIT_INIT: assert property (
    $rose(rstn_in) |-> user_limit_value_out == LIMIT_INIT)
    else $error("limit not loaded at startup");
  AST_B_ANSWER: assert property (
    (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out) |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response late");
  AST_W_BLOCK: assert property (
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while response pending");
  AST_B_DROP: assert property (
    s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out
      && s_axi_awready_out && s_axi_wready_out)
    else $error("write response not retired");
  AST_R_ANSWER: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out
      && !s_axi_arready_out)
    else $error("read answer not next cycle");
  AST_R_DROP: assert property (
    s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out
      && s_axi_arready_out)
    else $error("read answer not retired");
endmodule : tpd_top_asserts

bind tpd_top tpd_top_asserts #(.LIMIT_INIT(LIMIT_INIT)) u_tpd_chk (
  .clk_in(clk_in), .rstn_in(rstn_in),
  .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .tap_position_indication_out(tap_position_indication_out),
  .tap_valid_out(tap_valid_out),
  .user_limit_value_out(user_limit_value_out)
);

// ==== tb/tpd_top_test.sv ====
// testbench: register traffic, tap decoding, pulse metering, scaling
// assumes the field model drives the pins; responses checked from a queue
`timescale 1ns/100ps
module tpd_top_test
  import tpd_pkg::*;
;
  typedef struct {
    logic [7:0]  a;
    logic [33:0] e;
    logic [33:0] m;
  } tpd_note_type;
  localparam logic [33:0] ALL = 34'h3ffffffff;
  tpd_note_type q[$];
  tpd_note_type x;
  logic clk_in = 1'b0, rstn_in = 1'b0, aw_v = 1'b0, w_v = 1'b0;
  logic b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0, r_d, rd_v, lim_v, pm_v, mv_v;
  logic [15:0] mv = 16'h0, word;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, pulse, rev, tv, bl;
  logic [1:0] b_rs, r_rs;
  logic [5:0] pos;
  logic [33:0] v;
  logic [63:0] t;
  int bad_count = 0, comparisons = 0, cyc = 0;
  tpd_field_model i_tpd_field_model (.clk_in(clk_in), .word_out(word),
    .pulse_out(pulse), .reverse_out(rev));
  tpd_top #(.LIMIT_INIT(32'h00000078)) i_tpd_top (.clk_in(clk_in),
    .rstn_in(rstn_in), .binary_input_in(word), .pulse_in(pulse),
    .reverse_flow_in(rev), .mv_in(mv), .s_axi_awaddr_in(aw_a),
    .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_rdy),
    .s_axi_wdata_in(w_d), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_v),
    .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_rs),
    .s_axi_bvalid_out(b_v), .s_axi_bready_in(b_r),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_d),
    .s_axi_rresp_out(r_rs), .s_axi_rvalid_out(r_v),
    .s_axi_rready_in(r_r), .tap_position_indication_out(pos),
    .tap_valid_out(tv), .pulse_metered_value_out(pm_v),
    .user_measured_value_out(mv_v), .user_limit_value_out(lim_v),
    .below_limit_out(bl));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  task close_out;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // monitor: each response retires the oldest note
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if ((b_v & b_r) === 1'b1 || (r_v & r_r) === 1'b1) begin
      v = ((b_v & b_r) === 1'b1) ? {b_rs, 32'h0} : {r_rs, r_d};
      x = q.pop_front();
      comparisons++;
      if ((v & x.m) !== x.e) begin
        bad_count++;
        $display("mismatch reg %h expected %h seen %h", x.a, x.e, v);
      end
    end
    if (cyc == 30000) begin
      bad_count++;
      close_out();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw;
    q.push_back('{a, {r, 32'h0}, 34'h300000000});
    @(posedge clk_in);
    {aw_a, w_d, aw_v, w_v, b_r} <= {a, d, 3'h7};
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(posedge clk_in);
      if (!ta && aw_rdy === 1'b1) begin
        ta = 1'b1;
        aw_v <= 1'b0;
      end
      if (!tw && w_rdy === 1'b1) begin
        tw = 1'b1;
        w_v <= 1'b0;
      end
    end
    do @(posedge clk_in); while (b_v !== 1'b1);
    b_r <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    q.push_back('{a, e, m});
    @(posedge clk_in);
    {ar_a, ar_v, r_r} <= {a, 2'h3};
    do @(posedge clk_in); while (ar_rdy !== 1'b1);
    ar_v <= 1'b0;
    do @(posedge clk_in); while (r_v !== 1'b1);
    r_r <= 1'b0;
  endtask : rd
  task tap(input logic [1:0] c, input logic [31:0] cfg,
           input logic [15:0] w, input logic [5:0] p);
    wr(ADDR_CTRL, {30'h0, c}, RESP_OKAY);
    wr(ADDR_TAP_CFG, cfg, RESP_OKAY);
    i_tpd_field_model.set_word(w);
    repeat (6) @(posedge clk_in);
    rd(ADDR_TAP_ST, {25'h0, p != POS_INVALID, 2'h0, p}, 34'h30000013f);
  endtask : tap
  initial begin
    void'($urandom(19));
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(ADDR_TAP_CFG, {2'h0, TAP_CFG_RST}, ALL);
    rd(ADDR_MFACT, {2'h0, MFACT_RST}, ALL);
    rd(ADDR_MV_CFG, {2'h0, MV_CFG_RST}, ALL);
    rd(ADDR_LIMIT, 34'h000000078, ALL);
    rd(8'h3c, {RESP_SLVERR, 32'h0}, ALL);
    wr(8'h3c, 32'h1, RESP_SLVERR);
    wr(ADDR_COUNT, 32'h1, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      t[5:0] = (i == 0 || i > 4) ? POS_INVALID : 6'(i + 2);
      tap(2'h0, 32'h01020304, (16'($urandom) & 16'hfff8) | 16'(i), t[5:0]);
      rd(ADDR_TAP_ST, {2'h0, 16'(i), 16'h0}, 34'h3ffff0000);
    end
    tap(2'h0, 32'h02000304, 16'h0003, 6'h06);
    tap(2'h0, 32'h013d0304, 16'h0002, POS_INVALID);
    tap(2'h0, 32'h0100063e, 16'h003e, POS_MAX);
    tap(2'h0, 32'h0100063e, 16'h003f, POS_INVALID);
    tap(2'h1, 32'h0100083e, 16'h0025, 6'h19);
    tap(2'h1, 32'h0100083e, 16'h001a, POS_INVALID);
    tap(2'h2, 32'h01000404, 16'h0004, 6'h03);
    tap(2'h2, 32'h01000404, 16'h0006, POS_INVALID);
    tap(2'h2, 32'h01000404, 16'h0000, POS_INVALID);
    // entry 0 defined first: the idle word indexes it in table mode
    wr(ADDR_TBL_DAT, 32'h0, RESP_OKAY);
    wr(ADDR_TBL_IDX, 32'h5, RESP_OKAY);
    wr(ADDR_TBL_DAT, 32'h11, RESP_OKAY);
    rd(ADDR_TBL_DAT, 34'h11, ALL);
    tap(2'h3, 32'h0100083e, 16'h0005, 6'h11);
    tap(2'h3, 32'h0100083e, 16'h0045, POS_INVALID);
    wr(ADDR_CTRL, 32'h8, RESP_OKAY);
    i_tpd_field_model.pulses(5);
    repeat (6) @(posedge clk_in);
    rd(ADDR_COUNT, 34'h5, ALL);
    wr(ADDR_CTRL, 32'hc, RESP_OKAY);
    i_tpd_field_model.pulses(5);
    repeat (6) @(posedge clk_in);
    rd(ADDR_COUNT, 34'ha, ALL);
    wr(ADDR_MFACT, 32'h4, RESP_OKAY);
    repeat (100) @(posedge clk_in);
    rd(ADDR_READING, 34'h2, ALL);
    i_tpd_field_model.set_flow(1'b1);
    repeat (100) @(posedge clk_in);
    rd(ADDR_READING, 34'h0fffffffe, ALL);
    for (int d = 0; d < 4; d++) begin
      @(posedge clk_in);
      mv <= 16'($urandom) & 16'h7fff;
      wr(ADDR_MV_CFG, {6'h0, 2'(d), 8'h41, 16'h0096}, RESP_OKAY);
      repeat (4) @(posedge clk_in);
      rd(ADDR_MV_CFG, {8'h0, 2'(d), 8'h41, 16'h0096}, ALL);
      t = (64'h96 * 64'(mv) * 64'(10 ** d)) >> 15;
      rd(ADDR_MV_VAL, {2'h0, t[31:0]}, ALL);
    end
    wr(ADDR_LIMIT, 32'h64, RESP_OKAY);
    rd(ADDR_LIMIT, 34'h64, ALL);
    comparisons++;
    if (bl !== (t[31:0] < 32'h64)) begin
      bad_count++;
      $display("mismatch below_limit expected %b seen %b",
               t[31:0] < 32'h64, bl);
    end
    close_out();
  end
endmodule : tpd_top_test
